//--- src/rsc_defs.vh
// register map, field layout and encodings for the regulator slot control block
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

`define RSC_CTRL_BASE 16'h4068
`define RSC_ON_BASE 16'h4069
`define RSC_SLEEP_BASE 16'h406a
`define RSC_REG_STRIDE 3
`define RSC_IRQ_STATUS 16'h4100
`define RSC_IRQ_MASK 16'h4101

`define RSC_CTRL_RESET 16'h0200
`define RSC_ON_RESET 16'h0000
`define RSC_SLEEP_RESET 16'h0000
`define RSC_CTRL_WMASK 16'hdfc1
`define RSC_ON_WMASK 16'he11f
`define RSC_SLEEP_WMASK 16'he11f

`define RSC_UV_ACT_HI 15
`define RSC_UV_ACT_LO 14
`define RSC_HWC_SRC_HI 12
`define RSC_HWC_SRC_LO 11
`define RSC_HWC_VSEL_BIT 10
`define RSC_HWC_MODE_HI 9
`define RSC_HWC_MODE_LO 8
`define RSC_FLOAT_BIT 7
`define RSC_SWITCH_BIT 6
`define RSC_LP_VAR_BIT 0
`define RSC_SLOT_HI 15
`define RSC_SLOT_LO 13
`define RSC_MODE_BIT 8
`define RSC_VSEL_HI 4
`define RSC_VSEL_LO 0

`define RSC_UV_SHUT_REG 2'h1
`define RSC_UV_RESET_DEV 2'h2
`define RSC_HWC_SRC_1 2'h1
`define RSC_HWC_SRC_2 2'h2
`define RSC_HWC_SRC_ANY 2'h3
`define RSC_HWC_MODE_OFF 2'h1
`define RSC_HWC_MODE_ON 2'h3

`define RSC_SLOT_NEVER 3'h0
`define RSC_SLOT_HWEN1 3'h6
`define RSC_SLOT_HWEN2 3'h7
`define RSC_SLP_TS5_TRANS 3'h0
`define RSC_SLP_TS3_TRANS 3'h6
`define RSC_SLP_TS1_TRANS 3'h7
`define RSC_SLP_DIS_BASE 3'h6
`define RSC_TS1 3'h1
`define RSC_TS3 3'h3
`define RSC_TS5 3'h5

`endif

//--- src/rsc_sync.v
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none
module rsc_sync #(
	parameter WIDTH = 1
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule // rsc_sync
`default_nettype wire

//--- src/rsc_out_sel.v
// per-regulator output selection: voltage code, mode and enable from state and hardware control
`timescale 1ns/1ns
`default_nettype none
`include "rsc_defs.vh"
module rsc_out_sel (
	input wire i_clk,
	input wire i_sys_rst,
	input wire [15:0] i_ctrl,
	input wire [15:0] i_on_cfg,
	input wire [15:0] i_sleep_cfg,
	input wire i_enabled,
	input wire i_sleeping,
	input wire i_hwc_active,
	output reg o_en,
	output reg [4:0] o_vsel,
	output reg o_low_power,
	output reg o_lp_variant,
	output reg o_float,
	output reg o_switch
);
	wire [1:0] hwc_mode = i_ctrl[`RSC_HWC_MODE_HI:`RSC_HWC_MODE_LO];
	wire [4:0] on_v = i_on_cfg[`RSC_VSEL_HI:`RSC_VSEL_LO];
	wire [4:0] slp_v = i_sleep_cfg[`RSC_VSEL_HI:`RSC_VSEL_LO];
	reg en_nxt;
	reg [4:0] vsel_nxt;
	reg lp_nxt;

	always @* begin
		en_nxt = i_enabled;
		vsel_nxt = on_v;
		lp_nxt = i_on_cfg[`RSC_MODE_BIT];
		if (i_hwc_active) begin
			vsel_nxt = i_ctrl[`RSC_HWC_VSEL_BIT] ? slp_v : on_v;
			case (hwc_mode)
				`RSC_HWC_MODE_OFF: begin
					en_nxt = 1'b0;
					lp_nxt = 1'b0;
				end
				`RSC_HWC_MODE_ON: begin
					lp_nxt = i_on_cfg[`RSC_MODE_BIT];
				end
				default: begin
					lp_nxt = 1'b1;
				end
			endcase
		end else if (i_sleeping) begin
			vsel_nxt = slp_v;
			lp_nxt = i_sleep_cfg[`RSC_MODE_BIT];
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_en <= 1'b0;
			o_vsel <= 5'h00;
			o_low_power <= 1'b0;
			o_lp_variant <= 1'b0;
			o_float <= 1'b0;
			o_switch <= 1'b0;
		end else begin
			o_en <= en_nxt;
			o_vsel <= vsel_nxt;
			o_low_power <= lp_nxt;
			o_lp_variant <= i_ctrl[`RSC_LP_VAR_BIT];
			o_float <= i_ctrl[`RSC_FLOAT_BIT];
			o_switch <= i_ctrl[`RSC_SWITCH_BIT];
		end
	end
endmodule // rsc_out_sel
`default_nettype wire

//--- src/rsc_regulator_slot_control.v
// register file, sequencing state and undervoltage handling for six regulator slots
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rsc_defs.vh"
module rsc_regulator_slot_control #(
	parameter NREG = 6
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire [15:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output wire [15:0] o_rdata,
	input wire i_otp_load,
	input wire [3*NREG-1:0] i_otp_on_slot,
	input wire [5*NREG-1:0] i_otp_on_vsel,
	input wire i_seq_stb,
	input wire i_seq_shutdown,
	input wire [2:0] i_seq_slot,
	input wire i_hardware_control_input_1,
	input wire i_hardware_control_input_2,
	input wire i_hw_enable_1,
	input wire i_hw_enable_2,
	input wire [NREG-1:0] i_undervoltage,
	output wire [NREG-1:0] o_reg_en,
	output wire [5*NREG-1:0] o_reg_vsel,
	output wire [NREG-1:0] o_reg_low_power,
	output wire [NREG-1:0] o_reg_lp_variant,
	output wire [NREG-1:0] o_reg_float,
	output wire [NREG-1:0] o_reg_switch,
	output wire o_dev_reset_req,
	output wire o_irq
);
	// pins from outside the clock domain
	wire [NREG+3:0] pins_sync;
	wire hwc1_s;
	wire hwc2_s;
	wire hwen1_s;
	wire hwen2_s;
	wire [NREG-1:0] uv_s;

	rsc_sync #(
		.WIDTH(NREG+4)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_undervoltage, i_hw_enable_2, i_hw_enable_1,
			i_hardware_control_input_2, i_hardware_control_input_1}),
		.o_sync(pins_sync)
	);

	assign hwc1_s = pins_sync[0];
	assign hwc2_s = pins_sync[1];
	assign hwen1_s = pins_sync[2];
	assign hwen2_s = pins_sync[3];
	assign uv_s = pins_sync[NREG+3:4];

	// edge detect on the already synchronised level
	reg [NREG-1:0] uv_prev_r;
	wire [NREG-1:0] uv_event = uv_s & ~uv_prev_r;

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			uv_prev_r <= {NREG{1'b0}};
		end else begin
			uv_prev_r <= uv_s;
		end
	end

	// interrupt status and mask
	reg [NREG-1:0] irq_status_r;
	reg [NREG-1:0] irq_mask_r;
	wire hit_status = (i_addr == `RSC_IRQ_STATUS);
	wire hit_mask = (i_addr == `RSC_IRQ_MASK);
	wire [NREG-1:0] status_clr = (i_wr && hit_status) ? i_wdata[NREG-1:0] : {NREG{1'b0}};

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			irq_status_r <= {NREG{1'b0}};
			irq_mask_r <= {NREG{1'b0}};
		end else begin
			// a new event beats a clear in the same cycle
			irq_status_r <= (irq_status_r & ~status_clr) | uv_event;
			if (i_wr && hit_mask) begin
				irq_mask_r <= i_wdata[NREG-1:0];
			end
		end
	end

	assign o_irq = |(irq_status_r & irq_mask_r);

	// device reset request, one cycle per cycle with an offending event; simultaneous events share one pulse
	wire [NREG-1:0] uv_reset_hit;
	reg dev_reset_r;

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			dev_reset_r <= 1'b0;
		end else begin
			dev_reset_r <= |uv_reset_hit;
		end
	end

	assign o_dev_reset_req = dev_reset_r;

	// per-regulator registers and state
	wire [16*NREG-1:0] rd_bus;
	wire [NREG-1:0] rd_hit;

	// per-regulator sequencing states, one-hot
	localparam [2:0] ST_OFF = 3'h1;
	localparam [2:0] ST_ON = 3'h2;
	localparam [2:0] ST_SLEEP = 3'h4;

	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			localparam integer A_CTRL = `RSC_CTRL_BASE + g * `RSC_REG_STRIDE;
			localparam integer A_ON = `RSC_ON_BASE + g * `RSC_REG_STRIDE;
			localparam integer A_SLP = `RSC_SLEEP_BASE + g * `RSC_REG_STRIDE;
			wire hit_ctrl = (i_addr == A_CTRL[15:0]);
			wire hit_on = (i_addr == A_ON[15:0]);
			wire hit_slp = (i_addr == A_SLP[15:0]);
			reg [15:0] ctrl_r;
			reg [15:0] on_r;
			reg [15:0] slp_r;
			reg [2:0] state_r;
			reg [2:0] state_nxt;
			reg uv_off_r;
			reg uv_shut;
			reg uv_reset;
			wire en_state = (state_r == ST_ON) || (state_r == ST_SLEEP);
			wire sleep_state = (state_r == ST_SLEEP);
			wire [2:0] on_slot = on_r[`RSC_SLOT_HI:`RSC_SLOT_LO];
			wire [2:0] slp_slot = slp_r[`RSC_SLOT_HI:`RSC_SLOT_LO];
			wire [1:0] uv_act = ctrl_r[`RSC_UV_ACT_HI:`RSC_UV_ACT_LO];
			wire [1:0] hwc_src = ctrl_r[`RSC_HWC_SRC_HI:`RSC_HWC_SRC_LO];
			wire hw_assigned = (on_slot == `RSC_SLOT_HWEN1) || (on_slot == `RSC_SLOT_HWEN2);
			wire hwen_level = (on_slot == `RSC_SLOT_HWEN1) ? hwen1_s : hwen2_s;
			wire [2:0] dis_slot = `RSC_SLP_DIS_BASE - slp_slot;
			wire slp_coded = (slp_slot != `RSC_SLP_TS5_TRANS) && (slp_slot < `RSC_SLP_TS3_TRANS);
			wire startup_hit = i_seq_stb && !i_seq_shutdown;
			wire shutdown_hit = i_seq_stb && i_seq_shutdown;
			reg hwc_active;
			reg to_sleep;
			reg to_off;

			// hardware control source
			always @* begin
				case (hwc_src)
					`RSC_HWC_SRC_1: hwc_active = hwc1_s;
					`RSC_HWC_SRC_2: hwc_active = hwc2_s;
					`RSC_HWC_SRC_ANY: hwc_active = hwc1_s | hwc2_s;
					default: hwc_active = 1'b0;
				endcase
			end

			// shutdown timeslot decode
			always @* begin
				to_sleep = 1'b0;
				to_off = 1'b0;
				if (shutdown_hit) begin
					case (slp_slot)
						`RSC_SLP_TS5_TRANS: to_sleep = (i_seq_slot == `RSC_TS5);
						`RSC_SLP_TS3_TRANS: to_sleep = (i_seq_slot == `RSC_TS3);
						`RSC_SLP_TS1_TRANS: to_sleep = (i_seq_slot == `RSC_TS1);
						default: begin
							if (slp_coded && i_seq_slot == dis_slot) begin
								if (hw_assigned) begin
									to_sleep = 1'b1;
								end else begin
									to_off = 1'b1;
								end
							end
						end
					endcase
				end
			end

			// undervoltage action decode; reserved 11 behaves as ignore
			always @* begin
				uv_shut = 1'b0;
				uv_reset = 1'b0;
				case (uv_act)
					`RSC_UV_SHUT_REG: begin
						uv_shut = uv_event[g];
					end
					`RSC_UV_RESET_DEV: begin
						uv_reset = uv_event[g];
					end
					default: begin
						uv_shut = 1'b0;
						uv_reset = 1'b0;
					end
				endcase
			end

			assign uv_reset_hit[g] = uv_reset;

			// registers: software writes, OTP load of on slot and voltage
			always @(posedge i_clk) begin
				if (i_sys_rst) begin
					ctrl_r <= `RSC_CTRL_RESET;
					on_r <= `RSC_ON_RESET;
					slp_r <= `RSC_SLEEP_RESET;
				end else begin
					if (i_wr && hit_ctrl) begin
						ctrl_r <= i_wdata & `RSC_CTRL_WMASK;
					end
					if (i_otp_load) begin
						// otp wins over a simultaneous software write
						on_r[`RSC_SLOT_HI:`RSC_SLOT_LO] <= i_otp_on_slot[3*g+2:3*g];
						on_r[`RSC_VSEL_HI:`RSC_VSEL_LO] <= i_otp_on_vsel[5*g+4:5*g];
					end else if (i_wr && hit_on) begin
						on_r <= i_wdata & `RSC_ON_WMASK;
					end
					if (i_wr && hit_slp) begin
						slp_r <= i_wdata & `RSC_SLEEP_WMASK;
					end
				end
			end

			// sequencing state: off, on or sleeping
			always @* begin
				state_nxt = state_r;
				if (hw_assigned) begin
					// dropping the enable level also ends sleep
					if (!hwen_level) begin
						state_nxt = ST_OFF;
					end else if (to_sleep) begin
						state_nxt = ST_SLEEP;
					end else if (state_r == ST_OFF) begin
						state_nxt = ST_ON;
					end
				end else if (on_slot == `RSC_SLOT_NEVER) begin
					state_nxt = ST_OFF;
				end else if (startup_hit && i_seq_slot == on_slot) begin
					state_nxt = ST_ON;
				end else begin
					case (state_r)
						ST_ON: begin
							if (to_off) begin
								state_nxt = ST_OFF;
							end else if (to_sleep) begin
								state_nxt = ST_SLEEP;
							end
						end
						ST_SLEEP: begin
							if (to_off) begin
								state_nxt = ST_OFF;
							end
						end
						ST_OFF: begin
							state_nxt = ST_OFF;
						end
						default: begin
							state_nxt = ST_OFF;
						end
					endcase
				end
			end

			always @(posedge i_clk) begin
				if (i_sys_rst) begin
					state_r <= ST_OFF;
					uv_off_r <= 1'b0;
				end else begin
					state_r <= state_nxt;
					// a new event beats a clear of its status bit
					if (uv_shut) begin
						uv_off_r <= 1'b1;
					end else if (status_clr[g]) begin
						uv_off_r <= 1'b0;
					end
				end
			end

			rsc_out_sel u_out (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_ctrl(ctrl_r),
				.i_on_cfg(on_r),
				.i_sleep_cfg(slp_r),
				.i_enabled(en_state && !uv_off_r),
				.i_sleeping(sleep_state),
				.i_hwc_active(hwc_active),
				.o_en(o_reg_en[g]),
				.o_vsel(o_reg_vsel[5*g+4:5*g]),
				.o_low_power(o_reg_low_power[g]),
				.o_lp_variant(o_reg_lp_variant[g]),
				.o_float(o_reg_float[g]),
				.o_switch(o_reg_switch[g])
			);

			assign rd_hit[g] = hit_ctrl | hit_on | hit_slp;
			assign rd_bus[16*g+15:16*g] = hit_ctrl ? ctrl_r : hit_on ? on_r : hit_slp ? slp_r : 16'h0000;
		end
	endgenerate

	// read data, valid only in the cycle after the strobe
	reg [15:0] rdata_r;
	reg [15:0] rd_mux;
	integer k;
	wire rd_mapped = (|rd_hit) | hit_status | hit_mask;

	always @* begin
		rd_mux = 16'h0000;
		for (k = 0; k < NREG; k = k + 1) begin
			rd_mux = rd_mux | rd_bus[16*k +: 16];
		end
		if (hit_status) begin
			rd_mux = {{(16-NREG){1'b0}}, irq_status_r};
		end else if (hit_mask) begin
			rd_mux = {{(16-NREG){1'b0}}, irq_mask_r};
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_r <= 16'h0000;
		end else begin
			// unmapped addresses read zero
			rdata_r <= (i_rd && rd_mapped) ? rd_mux : 16'h0000;
		end
	end

	assign o_rdata = rdata_r;
endmodule // rsc_regulator_slot_control
`default_nettype wire

//--- testbench/rsc_monitor.sv
// checker for the regulator slot control top-level ports
`timescale 1ns/1ns
`default_nettype none
module rsc_monitor #(
	parameter NREG = 6
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic [NREG-1:0] o_reg_en,
	input wire logic [NREG-1:0] o_reg_float,
	input wire logic [NREG-1:0] o_reg_switch,
	input wire logic [NREG-1:0] o_reg_lp_variant,
	input wire logic o_dev_reset_req,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	rst_clears_a: assert property ($fell(i_sys_rst) |-> o_reg_en == '0 && !o_irq && o_rdata == 16'h0)
		else $error("outputs not cleared by reset");
	rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
		else $error("read data outside read cycle");
	unmapped_rd_a: assert property (i_rd && i_addr == 16'h4200 |=> o_rdata == 16'h0)
		else $error("unmapped read not zero");
	ctrl_rsvd_a: assert property (i_rd && i_addr == 16'h4068 |=> (o_rdata & ~16'hdfc1) == 16'h0)
		else $error("reserved control bits read back");
	wr_rd_echo_a: assert property (i_wr && i_addr == 16'h4068 ##1 !i_wr ##1 i_rd && i_addr == 16'h4068
		|=> o_rdata == ($past(i_wdata, 3) & 16'hdfc1))
		else $error("control write not read back");
	float_copy_a: assert property (i_wr && i_addr == 16'h4068 |-> ##2 o_reg_float[0] == $past(i_wdata[7], 2))
		else $error("float option not applied");
	switch_copy_a: assert property (i_wr && i_addr == 16'h4068 |-> ##2 o_reg_switch[0] == $past(i_wdata[6], 2))
		else $error("switch option not applied");
	lpvar_copy_a: assert property (i_wr && i_addr == 16'h4077 |-> ##2 o_reg_lp_variant[5] == $past(i_wdata[0], 2))
		else $error("low power variant not applied");
	irq_masked_a: assert property (i_wr && i_addr == 16'h4101 && i_wdata[5:0] == 6'h0 |=> !o_irq)
		else $error("interrupt with empty mask");
	cover property (o_dev_reset_req);
	cover property ($rose(o_irq));
	cover property ($fell(o_reg_en[1]));
endmodule // rsc_monitor
bind rsc_regulator_slot_control rsc_monitor #(.NREG(NREG)) u_mon (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_reg_en(o_reg_en), .o_reg_float(o_reg_float), .o_reg_switch(o_reg_switch),
	.o_reg_lp_variant(o_reg_lp_variant), .o_dev_reset_req(o_dev_reset_req), .o_irq(o_irq));
`default_nettype wire

//--- testbench/rsc_hw_pins.sv
// hardware control and hardware enable pin model
`timescale 1ns/1ns
`default_nettype none
module rsc_hw_pins (
	input wire logic i_clk,
	input wire logic [3:0] i_lvl,
	output logic o_hwc1,
	output logic o_hwc2,
	output logic o_hwen1,
	output logic o_hwen2
);
	initial {o_hwen2, o_hwen1, o_hwc2, o_hwc1} = 4'h0;
	// levels move off the sampling edge; the design synchronises them anyway
	always @(posedge i_clk) begin
		#1 {o_hwen2, o_hwen1, o_hwc2, o_hwc1} = i_lvl;
	end
endmodule // rsc_hw_pins
`default_nettype wire

//--- testbench/rsc_regulator_slot_control_tb.sv
// self-checking bench for the regulator slot control block
`timescale 1ns/1ns
`default_nettype none
module rsc_regulator_slot_control_tb;
	logic clk = 0, rst = 1, wr = 0, rd = 0, ld = 0, stb = 0, sdn = 0;
	logic [15:0] addr = '0, wd = '0;
	logic [2:0] slot = '0;
	logic [3:0] lvl = '0;
	logic [5:0] uv = '0;
	logic [17:0] os = 18'h02000;
	logic [29:0] ov = 30'h01100000;
	wire [15:0] rdata;
	wire [5:0] en, lp;
	wire [29:0] vs;
	wire drq, irq, h1, h2, e1, e2;
	int err_count = 0, total_checks = 0, npulse = 0;
	rsc_hw_pins pins (.i_clk(clk), .i_lvl(lvl), .o_hwc1(h1), .o_hwc2(h2), .o_hwen1(e1), .o_hwen2(e2));
	rsc_regulator_slot_control dut (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_otp_load(ld), .i_otp_on_slot(os), .i_otp_on_vsel(ov),
		.i_seq_stb(stb), .i_seq_shutdown(sdn), .i_seq_slot(slot), .i_hardware_control_input_1(h1),
		.i_hardware_control_input_2(h2), .i_hw_enable_1(e1), .i_hw_enable_2(e2), .i_undervoltage(uv),
		.o_reg_en(en), .o_reg_vsel(vs), .o_reg_low_power(lp), .o_reg_lp_variant(), .o_reg_float(),
		.o_reg_switch(), .o_dev_reset_req(drq), .o_irq(irq));
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (drq === 1'b1) npulse++;
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task ck(input [31:0] g, input [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task bw(input [15:0] a, input [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task br(input [15:0] a, input [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 ck(rdata, e);
	endtask
	task seq(input d, input [2:0] s);
		@(posedge clk);
		sdn <= d;
		slot <= s;
		stb <= 1;
		@(posedge clk);
		stb <= 0;
		tick(3);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		report_and_stop;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		tick(1);
		br(16'h4068, 16'h0200);
		br(16'h4077, 16'h0200);
		br(16'h406a, 16'h0000);
		bw(16'h4068, 16'hffff);
		br(16'h4068, 16'hdfc1);
		bw(16'h4077, 16'hffff);
		br(16'h4077, 16'hdfc1);
		bw(16'h4069, 16'hffff);
		br(16'h4069, 16'he11f);
		bw(16'h4200, 16'hffff);
		br(16'h4200, 16'h0000);
		$display("test registers done");
		bw(16'h4068, 16'h0200);
		bw(16'h4069, 16'h600a);
		bw(16'h406a, 16'hc11f);
		bw(16'h406c, 16'h2003);
		bw(16'h406d, 16'h6000);
		seq(0, 3'h1);
		ck(en[1:0], 2'b10);
		seq(0, 3'h3);
		ck(en[1:0], 2'b11);
		ck(vs[4:0], 5'h0a);
		ck(lp[0], 1'b0);
		$display("test startup done");
		@(posedge clk) lvl <= 4'h1;
		for (int i = 0; i < 4; i++) begin
			bw(16'h4068, {6'h03, i[1:0], 8'h00});
			tick(6);
			ck(en[0], i != 1);
			if (i != 1) ck(lp[0], i != 3);
			if (i != 1) ck(vs[4:0], 5'h1f);
		end
		// input 1 high must not matter to a source-2 slot
		bw(16'h4068, 16'h1700);
		tick(3);
		ck(vs[4:0], 5'h0a);
		bw(16'h4068, 16'h0200);
		@(posedge clk) lvl <= 4'h0;
		$display("test hardware control done");
		seq(1, 3'h3);
		ck(en[1:0], 2'b01);
		ck(vs[4:0], 5'h1f);
		ck(lp[0], 1'b1);
		$display("test sleep done");
		bw(16'h406f, 16'hc005);
		@(posedge clk) lvl <= 4'h4;
		tick(6);
		ck(en[2], 1'b1);
		ck(vs[14:10], 5'h05);
		bw(16'h4070, 16'h6107);
		seq(1, 3'h3);
		ck(en[2], 1'b1);
		ck(vs[14:10], 5'h07);
		ck(lp[2], 1'b1);
		@(posedge clk) lvl <= 4'h0;
		tick(6);
		ck(en[2], 1'b0);
		$display("test hardware enable done");
		bw(16'h4071, 16'h8200);
		bw(16'h4101, 16'h0018);
		@(posedge clk) uv <= 6'h18;
		tick(8);
		ck(irq, 1'b1);
		ck(npulse, 1);
		br(16'h4100, 16'h0018);
		bw(16'h4100, 16'h0008);
		br(16'h4100, 16'h0010);
		bw(16'h4101, 16'h0000);
		tick(1);
		ck(irq, 1'b0);
		$display("test undervoltage done");
		@(posedge clk) ld <= 1;
		@(posedge clk) ld <= 0;
		tick(1);
		br(16'h4075, 16'h4011);
		$display("test otp done");
		report_and_stop;
	end
endmodule // rsc_regulator_slot_control_tb
`default_nettype wire
